/* File: inc/duart_consts.svh */
// register indices, reset values and field positions of one uart channel
`ifndef DUART_CONSTS_SVH
`define DUART_CONSTS_SVH
`define IDX_HOLDING      4'h0
`define IDX_INT_ENABLE   4'h1
`define IDX_INT_STATUS   4'h2
`define IDX_LINE_CTRL    4'h3
`define IDX_MODEM_CTRL   4'h4
`define IDX_LINE_STATUS  4'h5
`define IDX_MODEM_STATUS 4'h6
`define IDX_SCRATCH      4'h7
`define IDX_DIV_LOW      4'h8
`define IDX_DIV_HIGH     4'h9
`define IDX_FRAC_DIV     4'hA
`define IDX_ENH_FEATURE  4'hB
`define IDX_ON_CHAR_ONE  4'hC
`define IDX_ON_CHAR_TWO  4'hD
`define IDX_OFF_CHAR_ONE 4'hE
`define IDX_OFF_CHAR_TWO 4'hF
`define RST_ZERO         8'h00
`define RST_DIV_LOW      8'h01
`define RST_DIV_HIGH     8'h00
`define RST_SCRATCH      8'hFF
`define ISR_NONE         8'h01
`define ISR_LINE         8'h06
`define ISR_MODEM        8'h00
`define LSR_IDLE         8'h60
`define LSR_BREAK_BIT    4
`define IER_LINE_BIT     2
`define IER_MODEM_BIT    3
`define MCR_DTR_BIT      0
`define MCR_RTS_BIT      1
`define MCR_OUT1_BIT     2
`define MCR_OUT2_BIT     3
`define MCR_LOOP_BIT     4
`define LCR_BREAK_BIT    6
`define EFR_ENH_BIT      4
`define IER_ENH_MASK     8'hF0
`define MCR_ENH_MASK     8'hE0
`define FCR_ENH_MASK     8'h30
`endif

/* File: inc/duart_pkg.sv */
// shared types of the dual uart reset-state block
package duart_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] reg_idx_t;
  typedef logic [3:0] modem_bits_t;
endpackage

/* File: core/duart_channel_reset_state.sv */
// register bank and reset state of a two-channel uart
// Functional notes
// - each channel holds two flow-on and two flow-off characters, read and write
// - both channels take identical reset defaults independently
// - divisor high loads zero and divisor low loads one at power-up only
// - the reset pin leaves both integer divisor bytes untouched
// - reset clears fractional divisor, interrupt enable, fifo, line, modem control
// - reset clears enhanced feature and all four flow characters
// - interrupt status reads one after reset, nothing pending
// - line status reads 0x60 after reset, transmitter empty, no errors
// - reset clears modem change bits; upper bits show inverted modem inputs
// - reset sets scratch pad to all ones
// - holding registers have no defined reset contents
// - in reset tx, output two, rts, dtr, rx-ready high; tx-ready low
// - in reset interrupt floats in 16 mode, driven high in 68 mode
// - sleep isolates bus and serial receive inputs, modem inputs stay live
// - scratch pad survives sleep, reset only by reset or power cycle
//
// Added by the designer: the register offsets and the plain strobed port.
`include "duart_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module duart_channel_reset_state #(
  parameter int CHANNELS = 2
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 por_n_i,
  input  wire logic                 bus_mode_68_i,
  input  wire logic                 input_isolation_sleep_i,
  input  wire logic                 chan_sel_i,
  input  wire duart_pkg::reg_idx_t  addr_i,
  input  wire duart_pkg::byte_t     wdata_i,
  input  wire logic                 wr_strobe_i,
  input  wire logic                 rd_strobe_i,
  output var  duart_pkg::byte_t     rdata_o,
  input  wire logic [CHANNELS-1:0]  rx_i,
  input  wire logic [CHANNELS-1:0]  cts_n_i,
  input  wire logic [CHANNELS-1:0]  dsr_n_i,
  input  wire logic [CHANNELS-1:0]  ri_n_i,
  input  wire logic [CHANNELS-1:0]  cd_n_i,
  output logic      [CHANNELS-1:0]  tx_o,
  output logic      [CHANNELS-1:0]  general_output_two_n_o,
  output logic      [CHANNELS-1:0]  rts_n_o,
  output logic      [CHANNELS-1:0]  dtr_n_o,
  output logic      [CHANNELS-1:0]  receive_ready_n_o,
  output logic      [CHANNELS-1:0]  transmit_ready_n_o,
  output logic      [CHANNELS-1:0]  irq_o,
  output logic      [CHANNELS-1:0]  irq_oe_n_o
);
  import duart_pkg::*;

  // merge a write into a register, bits outside the mask keep old value
  function automatic byte_t merge_bits(input byte_t old_v, input byte_t new_v,
                                       input byte_t mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction

  // bus inputs forced idle while asleep
  wire       sleep_w = input_isolation_sleep_i;
  wire       wr_w    = wr_strobe_i & ~sleep_w;
  wire       rd_w    = rd_strobe_i & ~sleep_w;
  wire       csel_w  = chan_sel_i & ~sleep_w;
  reg_idx_t  addr_w;
  byte_t     wdata_w;
  assign addr_w  = sleep_w ? `IDX_HOLDING : addr_i;
  assign wdata_w = sleep_w ? `RST_ZERO : wdata_i;
  wire       any_rst_w = ~rst_n_i | ~por_n_i;

  byte_t rd_mux_w [CHANNELS];
  wire   ch_rd_w = csel_w;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      byte_t       div_low_reg, div_high_reg, frac_div_reg;
      byte_t       int_enable_reg, fifo_ctrl_reg, line_ctrl_reg, modem_ctrl_reg;
      byte_t       scratch_reg, enh_feature_reg;
      byte_t       on_one_reg, on_two_reg, off_one_reg, off_two_reg;
      modem_bits_t modem_delta_reg, modem_delta_next;
      modem_bits_t modem_prev_reg;
      logic        break_reg, break_next;
      modem_bits_t modem_now;
      byte_t       line_status_w, int_status_w, modem_status_w;
      logic        int_pend_w, line_int_w, modem_int_w;
      logic        enh_w, rx_iso_w;

      wire sel_w = (csel_w == 1'(g));
      wire wr_hit_w = wr_w & sel_w;
      wire rd_hit_w = rd_w & sel_w;
      wire loop_w = modem_ctrl_reg[`MCR_LOOP_BIT];
      assign enh_w = enh_feature_reg[`EFR_ENH_BIT];
      assign rx_iso_w = rx_i[g] | sleep_w;

      // status bits: cts, dsr, ri, cd in bits 4..7
      assign modem_now = loop_w ? {modem_ctrl_reg[`MCR_OUT2_BIT],
                                   modem_ctrl_reg[`MCR_OUT1_BIT],
                                   modem_ctrl_reg[`MCR_DTR_BIT],
                                   modem_ctrl_reg[`MCR_RTS_BIT]}
                                : ~{cd_n_i[g], ri_n_i[g], dsr_n_i[g], cts_n_i[g]};
      wire [3:0] modem_chg_w = {modem_now[3] ^ modem_prev_reg[3],
                                modem_prev_reg[2] & ~modem_now[2],
                                modem_now[1] ^ modem_prev_reg[1],
                                modem_now[0] ^ modem_prev_reg[0]};
      wire msr_rd_w = rd_hit_w & (addr_w == `IDX_MODEM_STATUS);
      wire lsr_rd_w = rd_hit_w & (addr_w == `IDX_LINE_STATUS);
      // new change wins over the clear by read
      assign modem_delta_next = (msr_rd_w ? 4'h0 : modem_delta_reg) | modem_chg_w;
      assign break_next = (lsr_rd_w ? 1'b0 : break_reg) | ~rx_iso_w;

      assign modem_status_w = {modem_now, modem_delta_reg};
      assign line_status_w  = `LSR_IDLE | (8'(break_reg) << `LSR_BREAK_BIT);
      assign line_int_w  = break_reg & int_enable_reg[`IER_LINE_BIT];
      assign modem_int_w = (|modem_delta_reg) & int_enable_reg[`IER_MODEM_BIT];
      assign int_pend_w  = line_int_w | modem_int_w;
      assign int_status_w = line_int_w  ? `ISR_LINE  :
                            modem_int_w ? `ISR_MODEM : `ISR_NONE;

      wire wr_sel_w [16];
      for (genvar r = 0; r < 16; r++) begin : g_wr
        assign wr_sel_w[r] = wr_hit_w & (addr_w == 4'(r));
      end

      // integer divisor: power-up only, reset pin has no effect
      always_ff @(posedge core_clk_i) begin
        if (!por_n_i) begin
          div_low_reg  <= `RST_DIV_LOW;
          div_high_reg <= `RST_DIV_HIGH;
        end else begin
          if (wr_sel_w[`IDX_DIV_LOW]) div_low_reg <= wdata_w;
          if (wr_sel_w[`IDX_DIV_HIGH]) div_high_reg <= wdata_w;
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (any_rst_w) begin
          frac_div_reg   <= `RST_ZERO;
          int_enable_reg <= `RST_ZERO;
          fifo_ctrl_reg  <= `RST_ZERO;
          line_ctrl_reg  <= `RST_ZERO;
          modem_ctrl_reg <= `RST_ZERO;
        end else begin
          if (wr_sel_w[`IDX_FRAC_DIV] && enh_w) frac_div_reg <= wdata_w;
          if (wr_sel_w[`IDX_INT_ENABLE])
            int_enable_reg <= merge_bits(int_enable_reg, wdata_w,
                                         enh_w ? 8'hFF : ~`IER_ENH_MASK);
          if (wr_sel_w[`IDX_INT_STATUS])
            fifo_ctrl_reg <= merge_bits(fifo_ctrl_reg, wdata_w,
                                        enh_w ? 8'hFF : ~`FCR_ENH_MASK);
          if (wr_sel_w[`IDX_LINE_CTRL]) line_ctrl_reg <= wdata_w;
          if (wr_sel_w[`IDX_MODEM_CTRL])
            modem_ctrl_reg <= merge_bits(modem_ctrl_reg, wdata_w,
                                         enh_w ? 8'hFF : ~`MCR_ENH_MASK);
        end
      end

      // sleep does not touch the scratch pad
      always_ff @(posedge core_clk_i) begin
        if (any_rst_w) begin
          scratch_reg     <= `RST_SCRATCH;
          enh_feature_reg <= `RST_ZERO;
          on_one_reg      <= `RST_ZERO;
          on_two_reg      <= `RST_ZERO;
          off_one_reg     <= `RST_ZERO;
          off_two_reg     <= `RST_ZERO;
        end else begin
          if (wr_sel_w[`IDX_SCRATCH]) scratch_reg <= wdata_w;
          if (wr_sel_w[`IDX_ENH_FEATURE]) enh_feature_reg <= wdata_w;
          if (wr_sel_w[`IDX_ON_CHAR_ONE]) on_one_reg <= wdata_w;
          if (wr_sel_w[`IDX_ON_CHAR_TWO]) on_two_reg <= wdata_w;
          if (wr_sel_w[`IDX_OFF_CHAR_ONE]) off_one_reg <= wdata_w;
          if (wr_sel_w[`IDX_OFF_CHAR_TWO]) off_two_reg <= wdata_w;
        end
      end

      always_ff @(posedge core_clk_i) begin
        if (any_rst_w) begin
          modem_delta_reg <= 4'h0;
          modem_prev_reg  <= modem_now;
          break_reg       <= 1'b0;
        end else begin
          modem_delta_reg <= modem_delta_next;
          modem_prev_reg  <= modem_now;
          break_reg       <= break_next;
        end
      end

      // holding registers: no receiver data, reads zero
      always_comb begin
        unique case (addr_w)
          `IDX_HOLDING:      rd_mux_w[g] = `RST_ZERO;
          `IDX_INT_ENABLE:   rd_mux_w[g] = int_enable_reg;
          `IDX_INT_STATUS:   rd_mux_w[g] = int_status_w;
          `IDX_LINE_CTRL:    rd_mux_w[g] = line_ctrl_reg;
          `IDX_MODEM_CTRL:   rd_mux_w[g] = modem_ctrl_reg;
          `IDX_LINE_STATUS:  rd_mux_w[g] = line_status_w;
          `IDX_MODEM_STATUS: rd_mux_w[g] = modem_status_w;
          `IDX_SCRATCH:      rd_mux_w[g] = scratch_reg;
          `IDX_DIV_LOW:      rd_mux_w[g] = div_low_reg;
          `IDX_DIV_HIGH:     rd_mux_w[g] = div_high_reg;
          `IDX_FRAC_DIV:     rd_mux_w[g] = frac_div_reg;
          `IDX_ENH_FEATURE:  rd_mux_w[g] = enh_feature_reg;
          `IDX_ON_CHAR_ONE:  rd_mux_w[g] = on_one_reg;
          `IDX_ON_CHAR_TWO:  rd_mux_w[g] = on_two_reg;
          `IDX_OFF_CHAR_ONE: rd_mux_w[g] = off_one_reg;
          `IDX_OFF_CHAR_TWO: rd_mux_w[g] = off_two_reg;
        endcase
      end

      // pin levels from reset-cleared controls
      always_ff @(posedge core_clk_i) begin
        if (any_rst_w) begin
          tx_o[g]                   <= 1'b1;
          general_output_two_n_o[g] <= 1'b1;
          rts_n_o[g]                <= 1'b1;
          dtr_n_o[g]                <= 1'b1;
          receive_ready_n_o[g]      <= 1'b1;
          transmit_ready_n_o[g]     <= 1'b0;
          irq_o[g]                  <= bus_mode_68_i;
          irq_oe_n_o[g]             <= ~bus_mode_68_i;
        end else begin
          tx_o[g]                   <= ~line_ctrl_reg[`LCR_BREAK_BIT] | loop_w;
          general_output_two_n_o[g] <= ~modem_ctrl_reg[`MCR_OUT2_BIT] | loop_w;
          rts_n_o[g]                <= ~modem_ctrl_reg[`MCR_RTS_BIT] | loop_w;
          dtr_n_o[g]                <= ~modem_ctrl_reg[`MCR_DTR_BIT] | loop_w;
          receive_ready_n_o[g]      <= 1'b1;
          transmit_ready_n_o[g]     <= 1'b0;
          irq_o[g]      <= bus_mode_68_i ? ~int_pend_w : int_pend_w;
          irq_oe_n_o[g] <= bus_mode_68_i ? 1'b0 :
                           ~modem_ctrl_reg[`MCR_OUT2_BIT];
        end
      end
    end
  endgenerate

  // read data valid the cycle after the strobe only
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= `RST_ZERO;
    end else if (rd_w) begin
      rdata_o <= rd_mux_w[ch_rd_w];
    end else begin
      rdata_o <= `RST_ZERO;
    end
  end

endmodule

`default_nettype wire

/* File: dv/duart_reset_checker.sv */
// reset-level and read-port assertions for the dual uart register bank
`include "duart_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module duart_reset_checker #(
  parameter int CHANNELS = 2
) (
  input wire logic                core_clk_i,
  input wire logic                rst_n_i,
  input wire logic                por_n_i,
  input wire logic                bus_mode_68_i,
  input wire logic                input_isolation_sleep_i,
  input wire duart_pkg::reg_idx_t addr_i,
  input wire logic                rd_strobe_i,
  input wire duart_pkg::byte_t    rdata_o,
  input wire logic [CHANNELS-1:0] rx_i,
  input wire logic [CHANNELS-1:0] tx_o,
  input wire logic [CHANNELS-1:0] general_output_two_n_o,
  input wire logic [CHANNELS-1:0] rts_n_o,
  input wire logic [CHANNELS-1:0] dtr_n_o,
  input wire logic [CHANNELS-1:0] receive_ready_n_o,
  input wire logic [CHANNELS-1:0] transmit_ready_n_o,
  input wire logic [CHANNELS-1:0] irq_o,
  input wire logic [CHANNELS-1:0] irq_oe_n_o
);
  import duart_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  wire in_rst = !(rst_n_i && por_n_i);
  wire rd_ok = rd_strobe_i && !input_isolation_sleep_i;
  a_rst_line_high: assert property (in_rst |=> &(tx_o & general_output_two_n_o))
    else $error("tx or output two not high in reset");
  a_rst_modem_high: assert property (in_rst |=> &(rts_n_o & dtr_n_o & receive_ready_n_o))
    else $error("modem or rx ready not high in reset");
  a_rst_transmit_ready_n_low: assert property (in_rst ##1 in_rst |-> transmit_ready_n_o == '0)
    else $error("tx ready not low in reset");
  a_rst_irq_oe: assert property (in_rst |=> irq_oe_n_o == {CHANNELS{!$past(bus_mode_68_i)}})
    else $error("irq enable wrong in reset");
  a_rst_irq_68: assert property (in_rst && bus_mode_68_i |=> &irq_o)
    else $error("irq not high in reset, 68 mode");
  a_sleep_no_read: assert property (disable iff (in_rst)
    input_isolation_sleep_i && rd_strobe_i |=> rdata_o == 8'h00)
    else $error("read answered while asleep");
  a_first_status: assert property ($rose(rst_n_i) && por_n_i && rd_ok
    && addr_i == `IDX_INT_STATUS |=> rdata_o == `ISR_NONE)
    else $error("status not idle after reset");
  a_lsr_idle: assert property (disable iff (in_rst) rd_ok && &rx_i
    && addr_i == `IDX_LINE_STATUS |=> rdata_o == `LSR_IDLE)
    else $error("line status not idle");
endmodule
bind duart_channel_reset_state duart_reset_checker #(.CHANNELS(CHANNELS)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .bus_mode_68_i(bus_mode_68_i),
  .input_isolation_sleep_i(input_isolation_sleep_i), .addr_i(addr_i), .rd_strobe_i(rd_strobe_i),
  .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .general_output_two_n_o(general_output_two_n_o),
  .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .receive_ready_n_o(receive_ready_n_o),
  .transmit_ready_n_o(transmit_ready_n_o), .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o));
`default_nettype wire

/* File: dv/host_model.sv */
// host processor model on the parallel register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic             clk_i,
  input  wire duart_pkg::byte_t rdata_i,
  output logic                  chan_sel_o,
  output duart_pkg::reg_idx_t   addr_o,
  output duart_pkg::byte_t      wdata_o,
  output logic                  wr_o,
  output logic                  rd_o
);
  import duart_pkg::*;
  initial begin
    {chan_sel_o, addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  // called just after a rising edge; one idle cycle follows each write
  task automatic wr(input logic ch, input reg_idx_t a, input byte_t d);
    chan_sel_o <= ch;
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic ch, input reg_idx_t a, output byte_t d);
    chan_sel_o <= ch;
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: dv/duart_channel_reset_state_bench.sv */
// self-checking bench for the dual uart reset-state register bank
`include "duart_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module duart_channel_reset_state_bench;
  import duart_pkg::*;
  logic clk, rst_n, por_n, mode68, sleep, csel, wr, rd;
  reg_idx_t addr;
  byte_t wdata, rdata, d;
  logic [1:0] rx, cts_n, dsr_n, ri_n, cd_n, tx, op2_n, rts_n, dtr_n, rxr_n, txr_n, irq, oe_n;
  int err_count, n_checks;
  // index, channel a value, channel b value
  localparam logic [19:0] ROWS [15] = '{20'h2_01_01, 20'h1_00_00, 20'h3_00_00, 20'h4_00_00,
    20'h5_60_60, 20'h6_10_80, 20'h7_FF_FF, 20'h8_01_01, 20'h9_00_00, 20'hA_00_00,
    20'hB_00_00, 20'hC_00_00, 20'hD_00_00, 20'hE_00_00, 20'hF_00_00};
  duart_channel_reset_state u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .por_n_i(por_n),
    .bus_mode_68_i(mode68), .input_isolation_sleep_i(sleep), .chan_sel_i(csel), .addr_i(addr),
    .wdata_i(wdata), .wr_strobe_i(wr), .rd_strobe_i(rd), .rdata_o(rdata), .rx_i(rx),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n), .tx_o(tx),
    .general_output_two_n_o(op2_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .receive_ready_n_o(rxr_n), .transmit_ready_n_o(txr_n), .irq_o(irq), .irq_oe_n_o(oe_n));
  host_model u_host (.clk_i(clk), .rdata_i(rdata), .chan_sel_o(csel), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic por);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (4) @(posedge clk);
    ck({6'h00, tx & op2_n & rts_n & dtr_n & rxr_n}, 8'h03);
    ck({6'h00, txr_n}, 8'h00);
    ck({6'h00, oe_n}, {6'h00, ~mode68, ~mode68});
    if (mode68) ck({6'h00, irq}, 8'h03);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    $display("reset test done");
  endtask
  // first read of each call is the channel a status register right after release
  task automatic check_table(input byte_t dl, input byte_t dh);
    byte_t e;
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 15; i++) begin
        e = c ? ROWS[i][7:0] : ROWS[i][15:8];
        if (ROWS[i][19:16] == `IDX_DIV_LOW) e = dl;
        if (ROWS[i][19:16] == `IDX_DIV_HIGH) e = dh;
        u_host.rd(c[0], ROWS[i][19:16], d);
        ck(d, e);
      end
    end
    $display("reset table test done");
  endtask
  initial begin
    {rst_n, por_n, mode68, sleep} = '0;
    rx = 2'b11;
    cts_n = 2'b10;
    dsr_n = 2'b11;
    ri_n = 2'b11;
    cd_n = 2'b01;
    do_reset(1'b1);
    check_table(`RST_DIV_LOW, `RST_DIV_HIGH);
    for (int c = 0; c < 2; c++) begin
      u_host.wr(c[0], `IDX_ENH_FEATURE, 8'h10);
      for (int i = 1; i < 16; i++) if (i != 11) u_host.wr(c[0], i[3:0], 8'h20 + i[7:0]);
      for (int i = 1; i < 16; i++) if (!(i inside {2, 5, 6, 11})) begin
        u_host.rd(c[0], i[3:0], d);
        ck(d, 8'h20 + i[7:0]);
      end
    end
    $display("program test done");
    do_reset(1'b0);
    check_table(8'h28, 8'h29);
    do_reset(1'b1);
    check_table(`RST_DIV_LOW, `RST_DIV_HIGH);
    u_host.wr(1'b0, `IDX_SCRATCH, 8'h5A);
    sleep <= 1'b1;
    u_host.wr(1'b0, `IDX_SCRATCH, 8'h11);
    u_host.rd(1'b0, `IDX_SCRATCH, d);
    ck(d, 8'h00);
    sleep <= 1'b0;
    u_host.rd(1'b0, `IDX_SCRATCH, d);
    ck(d, 8'h5A);
    $display("sleep test done");
    mode68 <= 1'b1;
    do_reset(1'b0);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
